// file: gpmc_power_mode_ctrl.sv
// Contract
// R1 - active mode measures all and watches undervoltage
// R2 - suspend/sleep stop measuring; limited blocks kept alive
// R3 - suspend entry: enable, idle low, nonzero interval, quiet current
// R4 - sleep entry: enable, idle low, interval zero
// R5 - undervoltage held for delay enters sleep
// R6 - undervoltage timing runs in both active kinds
// R7 - suspend timer expiry starts temporary active measurement
// R8 - quiet measurement returns to suspend
// R9 - loud measurement pulls io low, stays active
// R10 - data line rising edge wakes to active
// R11 - defaults: undervolt, enable off, interval zero
// R12 - power up starts in active mode
// R13 - threshold crossing raises the alarm interrupt
// R14 - alarm routed to data or io pin
// R15 - io pin also general purpose input output
// R16 - data pin standard or overdrive rate
// R17 - interval code picks suspend period, loaded on entry
// R18 - idle timer restarts whenever data line high
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ns
`include "gpmc_defs.svh"
module gpmc_power_mode_ctrl
  import gpmc_pkg::*;
#(
  parameter int unsigned IDLE_LOW_CYC = `GPMC_IDLE_LOW_MS * `GPMC_CLK_KHZ,
  parameter int unsigned UV_DELAY_CYC = `GPMC_UV_DELAY_MS * `GPMC_CLK_KHZ,
  parameter int unsigned MEAS_CYC = `GPMC_MEAS_MS * `GPMC_CLK_KHZ,
  parameter int unsigned SUSP_P1_CYC = `GPMC_SUSP_P1_MS * `GPMC_CLK_KHZ,
  parameter int unsigned SUSP_P2_CYC = `GPMC_SUSP_P2_MS * `GPMC_CLK_KHZ,
  parameter int unsigned SUSP_P3_CYC = `GPMC_SUSP_P3_MS * `GPMC_CLK_KHZ
)
(
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // data line pin
  input wire logic dq_in,
  output logic dq_out,
  output logic dq_oe_n,
  // programmable io pin
  input wire logic programmable_io_pin_in,
  output logic programmable_io_pin_out,
  output logic programmable_io_pin_oe_n,
  // measurement side
  input wire gpmc_meas_t meas,
  output gpmc_pwr_t pwr,
  output logic overdrive,
  // interrupt
  output logic irq
);

  // state
  gpmc_mode_t mode_q, mode_d;
  logic [5:0] ctrl_q; // control fields
  logic signed [15:0] chg_thr_q; // charge suspend threshold
  logic signed [15:0] dis_thr_q; // discharge suspend threshold
  logic [3:0] irq_stat_q; // sticky events
  logic [3:0] irq_mask_q; // event gate
  logic [1:0] gpio_q; // bit0 drive-low, bit1 sampled input
  logic dq_prev_q; // last data line level
  logic [31:0] idle_cnt_q; // idle-low counter
  logic [31:0] uv_cnt_q; // undervoltage counter
  logic [31:0] tmr_q; // suspend period timer
  logic wake_pin_q; // io held low by wake interrupt
  logic [31:0] prdata_q;
  logic pslverr_q; // error flag for the coming access phase
  gpmc_pwr_t pwr_q; // registered power domain controls
  logic irq_q;

  // field decode
  wire pmode_en = ctrl_q[`GPMC_CTRL_PMODE_BIT];
  wire uv_en = ctrl_q[`GPMC_CTRL_UNDERVOLT_SLEEP_ENABLE_BIT];
  wire [1:0] suspend_interval_select = ctrl_q[`GPMC_CTRL_PIE_LSB +: 2];
  wire alarm_on_io = ctrl_q[`GPMC_CTRL_ALARM_SEL_BIT];

  // suspend period table indexed by interval code
  function automatic logic [31:0] susp_period(input logic [1:0] code);
    unique case (code)
      2'b01: susp_period = SUSP_P1_CYC;
      2'b10: susp_period = SUSP_P2_CYC;
      2'b11: susp_period = SUSP_P3_CYC;
      default: susp_period = 32'h0000_0000;
    endcase
  endfunction

  // bus decode
  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = paddr == `GPMC_OFF_CTRL;
  wire hit_chg = paddr == `GPMC_OFF_CHG_THR;
  wire hit_dis = paddr == `GPMC_OFF_DIS_THR;
  wire hit_stat = paddr == `GPMC_OFF_STATUS;
  wire hit_istat = paddr == `GPMC_OFF_IRQ_STAT;
  wire hit_imask = paddr == `GPMC_OFF_IRQ_MASK;
  wire hit_gpio = paddr == `GPMC_OFF_GPIO;
  wire hit_any = hit_ctrl | hit_chg | hit_dis | hit_stat | hit_istat | hit_imask | hit_gpio;

  // condition decode
  wire in_active = (mode_q == GPMC_ACTIVE) || (mode_q == GPMC_TEMP_ACTIVE);
  wire dq_rise = dq_in && !dq_prev_q; // R10
  wire idle_expired = idle_cnt_q >= IDLE_LOW_CYC;
  wire cur_quiet = (meas.current < chg_thr_q) && (meas.current > dis_thr_q);
  wire uv_expired = uv_en && (uv_cnt_q >= UV_DELAY_CYC);
  wire tmr_done = tmr_q == 32'h0000_0000;

  // next mode and events
  logic ev_wake, ev_sleep, ev_susp;
  always_comb
  begin
    mode_d = mode_q;
    ev_wake = 1'b0;
    ev_sleep = 1'b0;
    ev_susp = 1'b0;
    unique case (mode_q)
      GPMC_ACTIVE:
      begin
        if (pmode_en && uv_expired)
        begin
          mode_d = GPMC_SLEEP; // R5
          ev_sleep = 1'b1;
        end
        else if (pmode_en && idle_expired && suspend_interval_select == 2'b00)
        begin
          mode_d = GPMC_SLEEP; // R4
          ev_sleep = 1'b1;
        end
        else if (pmode_en && idle_expired && suspend_interval_select != 2'b00 && meas.cur_valid && cur_quiet)
        begin
          mode_d = GPMC_SUSPEND; // R3
          ev_susp = 1'b1;
        end
      end
      GPMC_SUSPEND:
      begin
        if (dq_rise)
          mode_d = GPMC_ACTIVE; // R10
        else if (tmr_done)
          mode_d = GPMC_TEMP_ACTIVE; // R7
      end
      GPMC_TEMP_ACTIVE:
      begin
        if (dq_rise)
          mode_d = GPMC_ACTIVE; // R10
        else if (pmode_en && uv_expired)
        begin
          mode_d = GPMC_SLEEP; // R6
          ev_sleep = 1'b1;
        end
        else if (meas.cur_valid && cur_quiet)
          mode_d = GPMC_SUSPEND; // R8
        else if (meas.cur_valid)
        begin
          mode_d = GPMC_ACTIVE; // R9
          ev_wake = 1'b1;
        end
      end
      GPMC_SLEEP:
      begin
        if (dq_rise)
          mode_d = GPMC_ACTIVE; // R10
      end
    endcase
  end

  // mode register; reset lands in active
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      mode_q <= GPMC_ACTIVE; // R12
    else if (clk_en)
      mode_q <= mode_d;
  end

  // idle-low counter, cleared while the line is high
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      idle_cnt_q <= 32'h0000_0000;
    else if (clk_en)
    begin
      if (dq_in || !in_active)
        idle_cnt_q <= 32'h0000_0000; // R18
      else if (!idle_expired)
        idle_cnt_q <= idle_cnt_q + 32'h0000_0001;
    end
  end

  // undervoltage delay counter, runs in either active kind
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      uv_cnt_q <= 32'h0000_0000;
    else if (clk_en)
    begin
      if (!in_active || !meas.below_uv)
        uv_cnt_q <= 32'h0000_0000;
      else if (uv_cnt_q < UV_DELAY_CYC)
        uv_cnt_q <= uv_cnt_q + 32'h0000_0001; // R6
    end
  end

  // suspend period timer, reloaded on suspend entry
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      tmr_q <= 32'h0000_0000;
    else if (clk_en)
    begin
      if (mode_d == GPMC_SUSPEND && mode_q != GPMC_SUSPEND)
        tmr_q <= susp_period(suspend_interval_select) - 32'h0000_0001; // R17
      else if (mode_q == GPMC_SUSPEND && !tmr_done)
        tmr_q <= tmr_q - 32'h0000_0001; // R7
    end
  end

  // data line edge history
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      dq_prev_q <= 1'b1;
    else if (clk_en)
      dq_prev_q <= dq_in;
  end

  // wake interrupt hold on io pin, released by a data line wake
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      wake_pin_q <= 1'b0;
    else if (clk_en)
    begin
      if (ev_wake)
        wake_pin_q <= 1'b1; // R9
      else if (dq_rise)
        wake_pin_q <= 1'b0;
    end
  end

  // configuration registers
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q <= `GPMC_CTRL_RESET; // R11
      chg_thr_q <= 16'h0000;
      dis_thr_q <= 16'h0000;
      irq_mask_q <= 4'h0;
      gpio_q <= 2'b00;
    end
    else if (clk_en)
    begin
      gpio_q[1] <= programmable_io_pin_in; // R15
      if (wr && hit_ctrl)
        ctrl_q <= pwdata[5:0];
      if (wr && hit_chg)
        chg_thr_q <= pwdata[15:0];
      if (wr && hit_dis)
        dis_thr_q <= pwdata[15:0];
      if (wr && hit_imask)
        irq_mask_q <= pwdata[3:0];
      if (wr && hit_gpio)
        gpio_q[0] <= pwdata[0]; // R15
    end
  end

  // sticky events: set wins over write-one-to-clear
  wire [3:0] ev_vec = {ev_susp, ev_sleep, meas.alarm_cross, ev_wake}; // R13
  wire [3:0] w1c = (wr && hit_istat) ? pwdata[3:0] : 4'h0;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      irq_stat_q <= 4'h0;
      irq_q <= 1'b0;
    end
    else if (clk_en)
    begin
      irq_stat_q <= (irq_stat_q & ~w1c) | ev_vec;
      irq_q <= |(((irq_stat_q & ~w1c) | ev_vec) & irq_mask_q);
    end
  end

  // read mux
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (hit_ctrl)
      rd_mux = {26'h000_0000, ctrl_q};
    else if (hit_chg)
      rd_mux = {{16{chg_thr_q[15]}}, chg_thr_q};
    else if (hit_dis)
      rd_mux = {{16{dis_thr_q[15]}}, dis_thr_q};
    else if (hit_stat)
      rd_mux = {29'h0000_0000, wake_pin_q, mode_q};
    else if (hit_istat)
      rd_mux = {28'h000_0000, irq_stat_q};
    else if (hit_imask)
      rd_mux = {28'h000_0000, irq_mask_q};
    else if (hit_gpio)
      rd_mux = {30'h0000_0000, gpio_q};
  end

  // apb answer: zero wait, error on unmapped address
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      prdata_q <= 32'h0000_0000;
    else if (clk_en && psel && !penable)
      prdata_q <= rd_mux;
  end
  // error flag set in setup so it stands only through the access phase
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
      pslverr_q <= 1'b0;
    else if (clk_en)
      pslverr_q <= psel && !penable && !hit_any;
  end
  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = pslverr_q;

  // pin drive: alarm routed to the selected pin
  wire alarm_act = irq_stat_q[`GPMC_IRQ_ALARM_BIT];
  logic dq_oe_n_q, pio_oe_n_q;
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      dq_oe_n_q <= 1'b1;
      pio_oe_n_q <= 1'b1;
    end
    else if (clk_en)
    begin
      dq_oe_n_q <= !(alarm_act && !alarm_on_io); // R14
      pio_oe_n_q <= !(wake_pin_q || gpio_q[0] || (alarm_act && alarm_on_io)); // R9 R14
    end
  end
  assign dq_out = 1'b0;
  assign dq_oe_n = dq_oe_n_q;
  assign programmable_io_pin_out = 1'b0;
  assign programmable_io_pin_oe_n = pio_oe_n_q;
  assign irq = irq_q;

  // power domain controls and line rate
  always_ff @(posedge clk_sys or posedge rst)
  begin
    if (rst)
    begin
      pwr_q.meas_run <= 1'b1;
      pwr_q.lp_osc_run <= 1'b1;
      pwr_q.dq_buf_on <= 1'b1;
    end
    else if (clk_en)
    begin
      pwr_q.meas_run <= (mode_d == GPMC_ACTIVE) || (mode_d == GPMC_TEMP_ACTIVE); // R1 R2
      pwr_q.lp_osc_run <= mode_d != GPMC_SLEEP; // R2
      pwr_q.dq_buf_on <= 1'b1; // R2
    end
  end
  assign pwr = pwr_q;
  assign overdrive = ctrl_q[`GPMC_CTRL_OVERDRIVE_BIT]; // R16

endmodule

// file: gpmc_defs.svh
`ifndef GPMC_DEFS_SVH
`define GPMC_DEFS_SVH

// register byte offsets
`define GPMC_OFF_CTRL 12'h000
`define GPMC_OFF_CHG_THR 12'h004
`define GPMC_OFF_DIS_THR 12'h008
`define GPMC_OFF_STATUS 12'h00C
`define GPMC_OFF_IRQ_STAT 12'h010
`define GPMC_OFF_IRQ_MASK 12'h014
`define GPMC_OFF_GPIO 12'h018

// control register fields
`define GPMC_CTRL_PMODE_BIT 0
`define GPMC_CTRL_UNDERVOLT_SLEEP_ENABLE_BIT 1
`define GPMC_CTRL_PIE_LSB 2
`define GPMC_CTRL_ALARM_SEL_BIT 4
`define GPMC_CTRL_OVERDRIVE_BIT 5
`define GPMC_CTRL_RESET 6'h00

// interrupt status bits
`define GPMC_IRQ_WAKE_BIT 0
`define GPMC_IRQ_ALARM_BIT 1
`define GPMC_IRQ_SLEEP_BIT 2
`define GPMC_IRQ_SUSP_BIT 3

// timing, in ms, and clock rate in kHz
`define GPMC_CLK_KHZ 50000
`define GPMC_IDLE_LOW_MS 2100
`define GPMC_UV_DELAY_MS 82
`define GPMC_MEAS_MS 90
`define GPMC_SUSP_P1_MS 1000
`define GPMC_SUSP_P2_MS 2000
`define GPMC_SUSP_P3_MS 4000

`endif

// file: gpmc_pkg.sv
package gpmc_pkg;
  // power modes
  typedef enum logic [1:0]
  {
    GPMC_ACTIVE = 2'b00,
    GPMC_SUSPEND = 2'b01,
    GPMC_TEMP_ACTIVE = 2'b10,
    GPMC_SLEEP = 2'b11
  } gpmc_mode_t;

  // measurement results handed in by the datapath
  typedef struct packed
  {
    logic cur_valid;
    logic signed [15:0] current;
    logic below_uv;
    logic alarm_cross;
  } gpmc_meas_t;

  // power domain controls handed out
  typedef struct packed
  {
    logic meas_run;
    logic lp_osc_run;
    logic dq_buf_on;
  } gpmc_pwr_t;
endpackage

// file: gpmc_assertions.sv
`timescale 1ns/1ns
module gpmc_assertions
  import gpmc_pkg::*;
#(
  parameter int unsigned SUSP_P3_CYC = 20
)
(
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // bus and pins
  input wire logic psel,
  input wire logic penable,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic dq_in,
  input wire logic dq_out,
  input wire logic programmable_io_pin_out,
  // power domain controls
  input wire gpmc_pwr_t pwr
);
  // longest suspend stay before the next measurement
  localparam int SUSP_LIM = SUSP_P3_CYC + 4;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // a fresh step from measuring into suspend
  sequence s_susp_entry;
    !pwr.meas_run && pwr.lp_osc_run && $past(pwr.meas_run);
  endsequence
  // asleep while the data line stays low
  sequence s_sleep_low;
    !pwr.meas_run && !pwr.lp_osc_run && !dq_in;
  endsequence
  a_bus_no_wait: assert property (pready) else $error("bus wait seen");
  a_err_in_access: assert property (pslverr |-> psel && penable) else $error("stray error");
  a_pins_open_drain: assert property (!dq_out && !programmable_io_pin_out)
    else $error("pin driven high");
  a_start_active: assert property ($fell(rst) |-> pwr.meas_run)
    else $error("not active after reset");
  a_buffer_alive: assert property (pwr.dq_buf_on) else $error("data buffer off");
  a_wake_on_rise: assert property ($rose(dq_in) && !pwr.meas_run |-> ##[1:2] pwr.meas_run)
    else $error("no wake on rise");
  a_sleep_holds: assert property (s_sleep_low |=> !pwr.meas_run)
    else $error("left sleep early");
  a_susp_wakes: assert property (s_susp_entry |-> ##[1:SUSP_LIM] pwr.meas_run)
    else $error("suspend never measured");
endmodule
bind gpmc_power_mode_ctrl gpmc_assertions #(.SUSP_P3_CYC(SUSP_P3_CYC)) chk (.*);

// file: gpmc_pack_side.sv
`timescale 1ns/1ns
module gpmc_pack_side
(
  // gauge pin drives
  input wire logic dq_out,
  input wire logic dq_oe_n,
  input wire logic io_out,
  input wire logic io_oe_n,
  // host and pack controller pull requests
  input wire logic host_low,
  input wire logic mcu_low,
  // resolved pulled-up pin levels
  output logic dq_in,
  output logic io_in
);
  // shared data line: host or gauge may sink it
  assign dq_in = !host_low && (dq_oe_n || dq_out);
  // io pin shared with the pack controller
  assign io_in = !mcu_low && (io_oe_n || io_out);
endmodule

// file: test_gauge_power_mode_control.sv
`timescale 1ns/1ns
module test_gauge_power_mode_control
  import gpmc_pkg::*;
;
  localparam logic [32:0] ALL = 33'h1_ffff_ffff;
  // clock, reset, bus
  logic clk_sys = 0;
  logic rst = 1;
  logic clk_en = 1;
  logic psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready, pslverr, dq_in, dq_out, dq_oe_n, io_in, io_out, io_oe_n, overdrive, irq;
  // far side and measurement stimulus
  logic host_low = 0, mcu_low = 0, loud = 0;
  gpmc_meas_t meas = '0;
  gpmc_pwr_t pwr;
  logic [32:0] exp_q[$], msk_q[$];
  logic [15:0] lfsr = 16'h0060;
  int errors = 0, checked = 0, cyc = 0;
  always #10 clk_sys = ~clk_sys;
  gpmc_power_mode_ctrl #(.IDLE_LOW_CYC(20), .UV_DELAY_CYC(12), .MEAS_CYC(8),
    .SUSP_P1_CYC(16), .SUSP_P2_CYC(18), .SUSP_P3_CYC(20)) dut (.*,
    .programmable_io_pin_in(io_in), .programmable_io_pin_out(io_out),
    .programmable_io_pin_oe_n(io_oe_n));
  gpmc_pack_side pack (.*);
  function automatic logic [15:0] nxt(input logic [15:0] v);
    nxt = {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  // current result every fourth cycle while measuring
  always @(posedge clk_sys)
  begin
    cyc <= cyc + 1;
    lfsr <= nxt(lfsr);
    meas.cur_valid <= pwr.meas_run && (cyc % 4 == 3);
    meas.current <= loud ? 16'sh01f4 : {{9{lfsr[6]}}, lfsr[6:0]};
  end
  task automatic chk(input logic [32:0] got, input logic [32:0] e, input logic [32:0] m);
    checked++;
    if ((got & m) !== (e & m))
    begin
      errors++;
      $display("ERROR %0t got %h exp %h", $time, got, e);
    end
  endtask
  // compares each finished read with the oldest note
  always @(posedge clk_sys)
    if (psel && penable && pready && !pwrite && exp_q.size() > 0)
      chk({pslverr, prdata}, exp_q.pop_front(), msk_q.pop_front());
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    psel <= 1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 0;
    penable <= 0;
    @(posedge clk_sys);
  endtask
  task automatic rd(input logic [11:0] a, input logic [32:0] e, input logic [32:0] m);
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(0, a, 0);
  endtask
  task automatic wait_run(input logic v);
    int n;
    n = 0;
    while (pwr.meas_run !== v && n < 100)
    begin
      @(posedge clk_sys);
      n++;
    end
    chk(pwr.meas_run, v, 1);
  endtask
  task automatic final_report;
    $display("checked %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // main sequence
  initial
  begin
    repeat (3) @(posedge clk_sys);
    rst <= 0;
    @(posedge clk_sys);
    rd(12'h000, 0, ALL);
    rd(12'h00c, 0, 3);
    rd(12'h01c, 33'h1_0000_0000, ALL);
    mcu_low <= 1;
    repeat (2) @(posedge clk_sys);
    rd(12'h018, 0, 3);
    mcu_low <= 0;
    apb(1, 12'h018, 32'h0000_0001);
    repeat (2) @(posedge clk_sys);
    chk(io_in, 0, 1);
    apb(1, 12'h018, 32'h0000_0000);
    $display("defaults done");
    apb(1, 12'h000, 32'h0000_0021);
    chk(overdrive, 1, 1);
    host_low <= 1;
    repeat (15) @(posedge clk_sys);
    host_low <= 0;
    repeat (2) @(posedge clk_sys);
    host_low <= 1;
    repeat (15) @(posedge clk_sys);
    chk(pwr.meas_run, 1, 1);
    wait_run(0);
    rd(12'h00c, 3, 3);
    rd(12'h010, 4, 4);
    apb(1, 12'h010, 32'h0000_000f);
    rd(12'h010, 0, 15);
    apb(1, 12'h014, 32'h0000_000f);
    rd(12'h014, 15, 15);
    host_low <= 0;
    wait_run(1);
    $display("idle sleep done");
    apb(1, 12'h004, 32'h0000_0064);
    apb(1, 12'h008, 32'h0000_ff9c);
    apb(1, 12'h000, 32'h0000_0005);
    host_low <= 1;
    wait_run(0);
    rd(12'h00c, 1, 3);
    wait_run(1);
    wait_run(0);
    loud <= 1;
    wait_run(1);
    repeat (8) @(posedge clk_sys);
    rd(12'h00c, 4, 7);
    chk(io_in, 0, 1);
    host_low <= 0;
    loud <= 0;
    repeat (4) @(posedge clk_sys);
    chk(io_in, 1, 1);
    $display("suspend done");
    apb(1, 12'h000, 32'h0000_0003);
    meas.below_uv <= 1;
    repeat (8) @(posedge clk_sys);
    clk_en <= 0;
    repeat (10) @(posedge clk_sys);
    chk(pwr.meas_run, 1, 1);
    clk_en <= 1;
    wait_run(0);
    rd(12'h00c, 3, 3);
    meas.below_uv <= 0;
    host_low <= 1;
    repeat (2) @(posedge clk_sys);
    host_low <= 0;
    wait_run(1);
    meas.alarm_cross <= 1;
    @(posedge clk_sys);
    meas.alarm_cross <= 0;
    repeat (3) @(posedge clk_sys);
    chk(dq_in, 0, 1);
    chk(irq, 1, 1);
    rd(12'h010, 2, 2);
    $display("undervolt and alarm done");
    final_report();
  end
  // watchdog
  initial
  begin
    repeat (3000) @(posedge clk_sys);
    errors++;
    $display("ERROR %0t timeout", $time);
    final_report();
  end
endmodule
